/* design/control_byte_low_actions.sv */
/*
 Low control byte of the touch controller: takes the byte from the serial command
 decoder, holds the mode bits, defers the one-shot refresh and tuning requests to
 the end of the communication window and gates the opening of later windows.
 Assumes the serial decoder gives synchronous one-cycle strobes for the
 address-command and each data byte, and a level that is high during a window.
*/
`default_nettype none
// Notes on behaviour
// - Bit 4 of the low byte requests a proximity channel baseline refresh.
// - A 1 in bit 4 reloads the proximity channel average; a 0 leaves it alone.
// - The proximity refresh runs once and only after the current window has closed.
// - Bit 6 set lets the device pick the charging mode; clear hands the choice to bit 3.
// - With bit 6 clear, bit 3 picks normal channels (0) or the proximity channel (1).
// - A 1 in bit 2 starts tuning for the active mode's channels; a 0 starts nothing.
// - The device clears the tuning bit itself once the request is taken.
// - Tuning uses the proximity target and channel in proximity mode, else normal ones.
// - Tuning starts after the window closes and no new window opens until it ends.
// - A 1 in bit 1 reloads all trackpad channel averages; a 0 leaves them alone.
// - The host writes each refresh bit once and the device clears both after taking them.
// - The trackpad refresh waits until its window has closed.
// - With bit 0 clear a window opens on every processing cycle.
// - With bit 0 set windows are skipped until enabled activity or a forced window.
module control_byte_low_actions (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic addr_valid_i,
   input wire logic [7:0] addr_i,
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   input wire logic window_open_i,
   input wire logic cycle_tick_i,
   input wire logic activity_i,
   input wire logic force_window_i,
   input wire logic auto_choice_prox_i,
   input wire logic tune_done_i,
   output logic [7:0] control_byte_low_o,
   output logic proximity_charge_mode_o,
   output logic window_start_o,
   output logic pad_refresh_o,
   output logic prox_refresh_o,
   output logic tune_start_o,
   output logic tune_prox_mode_o,
   output logic tune_busy_o
);

   logic [7:0] ctrl_q;
   logic ctrl_sel_q;
   logic [1:0] byte_idx_q;
   logic window_q;
   logic window_close;
   logic take;
   logic low_write;
   logic prox_mode_d;
   logic seq_busy;
   logic tick_pend_q;
   logic seq_pad;
   logic seq_prox;
   logic seq_tune;
   // Hold-off and replay of window openings
   logic tune_take;
   logic hold_windows;
   logic tick_due;
   logic gate_ok;

   // Single bit of a control byte image
   function automatic logic field(input logic [7:0] b, input int pos);
      field = b[pos];
   endfunction

   // Any deferred request bit set in a control byte image
   function automatic logic any_one_shot(input logic [7:0] b);
      any_one_shot = (b & control_byte_low_pkg::ONE_SHOT_MASK) != 8'h00;
   endfunction

   // Window gating by the activity mode bit
   function automatic logic gate_allows(input logic [7:0] b, input logic act,
      input logic frc);
      gate_allows = !field(b, control_byte_low_pkg::BIT_COMM_ON_ACTIVITY) || act || frc;
   endfunction

   // Address-command that opens the two control bytes
   function automatic logic is_control_cmd(input logic [7:0] a);
      is_control_cmd = (a == control_byte_low_pkg::CONTROL_CMD_ADDR);
   endfunction

   // Command decode: track which data byte follows the control address
   // Bytes past the high byte are ignored until the next address-command
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_sel_q <= 1'b0;
         byte_idx_q <= control_byte_low_pkg::BYTE_IDX_LOW;
      end else if (addr_valid_i) begin
         ctrl_sel_q <= is_control_cmd(addr_i);
         byte_idx_q <= control_byte_low_pkg::BYTE_IDX_LOW;
      end else if (data_valid_i && byte_idx_q != control_byte_low_pkg::BYTE_IDX_DONE) begin
         byte_idx_q <= byte_idx_q + 2'h1;
      end
   end

   // Only the first data byte after the control address-command lands here
   assign low_write = data_valid_i && ctrl_sel_q
      && (byte_idx_q == control_byte_low_pkg::BYTE_IDX_LOW);

   // Window end: the registered level makes the close visible for one cycle only
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         window_q <= 1'b0;
      end else begin
         window_q <= window_open_i;
      end
   end

   assign window_close = window_q && !window_open_i;
   assign take = window_close && any_one_shot(ctrl_q);
   assign tune_take = take && field(ctrl_q, control_byte_low_pkg::BIT_AUTO_TUNING_TRIGGER);

   // Busy rises one edge after the take, so the take cycle itself must hold windows too
   assign hold_windows = seq_busy || tune_take;

   // Control byte; one-shot bits drop when taken, a write in the same cycle wins
   // A write in the take cycle keeps its own one-shot bits for the next close
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= control_byte_low_pkg::CONTROL_LOW_RESET;
      end else if (low_write) begin
         ctrl_q <= data_i;
      end else if (take) begin
         ctrl_q <= ctrl_q & ~control_byte_low_pkg::ONE_SHOT_MASK;
      end
   end

   // Effective charging mode
   // Follows bits 6 and 3 on every cycle, also while a tuning pass runs
   always_comb begin
      if (field(ctrl_q, control_byte_low_pkg::BIT_AUTO_MODE_SWITCH)) begin
         prox_mode_d = auto_choice_prox_i;
      end else begin
         prox_mode_d = field(ctrl_q, control_byte_low_pkg::BIT_CHARGE_MODE_SELECT);
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         proximity_charge_mode_o <= 1'b0;
      end else begin
         proximity_charge_mode_o <= prox_mode_d;
      end
   end

   // Readback copy of the byte, one cycle behind the working register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         control_byte_low_o <= control_byte_low_pkg::CONTROL_LOW_RESET;
      end else begin
         control_byte_low_o <= ctrl_q;
      end
   end

   // Mode for the tuning run is fixed when the request is taken
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tune_prox_mode_o <= 1'b0;
      end else if (tune_take) begin
         tune_prox_mode_o <= prox_mode_d;
      end
   end

   // The sequencer keeps its own copy of the requests, so the byte can drop
   // its one-shot bits in the same edge as the hand-over
   deferred_action_sequencer u_seq (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .take_i(take),
      .pad_req_i(field(ctrl_q, control_byte_low_pkg::BIT_TRACKPAD_REFRESH)),
      .prox_req_i(field(ctrl_q, control_byte_low_pkg::BIT_PROX_CHANNEL_REFRESH)),
      .tune_req_i(field(ctrl_q, control_byte_low_pkg::BIT_AUTO_TUNING_TRIGGER)),
      .tune_done_i(tune_done_i),
      .pad_refresh_o(seq_pad),
      .prox_refresh_o(seq_prox),
      .tune_start_o(seq_tune),
      .busy_o(seq_busy)
   );

   // Strobes come straight from the sequencer's output flops
   assign pad_refresh_o = seq_pad;
   assign prox_refresh_o = seq_prox;
   assign tune_start_o = seq_tune;
   assign tune_busy_o = seq_busy;

   // A cycle tick that falls while tuning is held waits for it to finish
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_pend_q <= 1'b0;
      end else if (cycle_tick_i && hold_windows) begin
         tick_pend_q <= 1'b1;
      end else if (!hold_windows) begin
         tick_pend_q <= 1'b0;
      end
   end

   // A held-over tick is replayed once and its gating checked again then
   always_comb begin
      tick_due = cycle_tick_i || tick_pend_q;
      gate_ok = gate_allows(ctrl_q, activity_i, force_window_i);
   end

   // Window opening per processing cycle, gated in activity mode
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         window_start_o <= 1'b0;
      end else begin
         window_start_o <= tick_due && gate_ok && !hold_windows;
      end
   end

endmodule // control_byte_low_actions
`default_nettype wire

/* pkg/control_byte_low_pkg.sv */
/*
 Constants for the low control byte of the touch controller: the command location,
 bit positions, the reset value and the states of the deferred action sequencer.
 Assumes nothing of its surroundings; every user writes package::name.
*/
`default_nettype none
package control_byte_low_pkg;

   // Address-command that carries the two control bytes
   localparam logic [7:0] CONTROL_CMD_ADDR = 8'h10;

   // Field positions inside control_byte_low
   localparam int BIT_COMM_ON_ACTIVITY = 0;
   localparam int BIT_TRACKPAD_REFRESH = 1;
   localparam int BIT_AUTO_TUNING_TRIGGER = 2;
   localparam int BIT_CHARGE_MODE_SELECT = 3;
   localparam int BIT_PROX_CHANNEL_REFRESH = 4;
   localparam int BIT_SINGLE_POINT = 5;
   localparam int BIT_AUTO_MODE_SWITCH = 6;
   localparam int BIT_RESET_ACK = 7;

   // Bits that the device clears itself once the request is taken
   localparam logic [7:0] ONE_SHOT_MASK = 8'h16;

   localparam logic [7:0] CONTROL_LOW_RESET = 8'h00;

   // Data bytes after the address-command: low byte, high byte, then ignored
   localparam logic [1:0] BYTE_IDX_LOW = 2'h0;
   localparam logic [1:0] BYTE_IDX_HIGH = 2'h1;
   localparam logic [1:0] BYTE_IDX_DONE = 2'h2;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_PAD_REFRESH = 3'b001,
      SEQ_PROX_REFRESH = 3'b010,
      SEQ_TUNE_START = 3'b011,
      SEQ_TUNE_WAIT = 3'b100
   } seq_state_e;

endpackage : control_byte_low_pkg
`default_nettype wire

/* design/deferred_action_sequencer.sv */
/*
 Holds the deferred actions taken from the low control byte and runs them,
 one after another in a fixed order, once the communication window has closed.
 Assumes take_i pulses only once the window has closed, and that tune_done_i
 pulses once when the tuning routine has finished.
*/
`default_nettype none
module deferred_action_sequencer (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic take_i,
   input wire logic pad_req_i,
   input wire logic prox_req_i,
   input wire logic tune_req_i,
   input wire logic tune_done_i,
   output logic pad_refresh_o,
   output logic prox_refresh_o,
   output logic tune_start_o,
   output logic busy_o
);

   control_byte_low_pkg::seq_state_e state_q;
   control_byte_low_pkg::seq_state_e state_d;
   logic pad_pend_q;
   logic prox_pend_q;
   logic tune_pend_q;

   // Pending flags: a new take wins over the clear of an issued action
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pad_pend_q <= 1'b0;
         prox_pend_q <= 1'b0;
         tune_pend_q <= 1'b0;
      end else begin
         if (take_i && pad_req_i) begin
            pad_pend_q <= 1'b1;
         end else if (state_d == control_byte_low_pkg::SEQ_PAD_REFRESH) begin
            pad_pend_q <= 1'b0;
         end
         if (take_i && prox_req_i) begin
            prox_pend_q <= 1'b1;
         end else if (state_d == control_byte_low_pkg::SEQ_PROX_REFRESH) begin
            prox_pend_q <= 1'b0;
         end
         if (take_i && tune_req_i) begin
            tune_pend_q <= 1'b1;
         end else if (state_d == control_byte_low_pkg::SEQ_TUNE_START) begin
            tune_pend_q <= 1'b0;
         end
      end
   end

   // Fixed order: trackpad refresh, proximity refresh, then tuning
   always_comb begin
      state_d = state_q;
      case (state_q)
         control_byte_low_pkg::SEQ_IDLE,
         control_byte_low_pkg::SEQ_PAD_REFRESH,
         control_byte_low_pkg::SEQ_PROX_REFRESH: begin
            if (pad_pend_q && state_q == control_byte_low_pkg::SEQ_IDLE) begin
               state_d = control_byte_low_pkg::SEQ_PAD_REFRESH;
            end else if (prox_pend_q && state_q != control_byte_low_pkg::SEQ_PROX_REFRESH) begin
               state_d = control_byte_low_pkg::SEQ_PROX_REFRESH;
            end else if (tune_pend_q) begin
               state_d = control_byte_low_pkg::SEQ_TUNE_START;
            end else begin
               state_d = control_byte_low_pkg::SEQ_IDLE;
            end
         end
         control_byte_low_pkg::SEQ_TUNE_START: begin
            state_d = control_byte_low_pkg::SEQ_TUNE_WAIT;
         end
         control_byte_low_pkg::SEQ_TUNE_WAIT: begin
            if (tune_done_i) begin
               state_d = control_byte_low_pkg::SEQ_IDLE;
            end
         end
         default: begin
            state_d = control_byte_low_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= control_byte_low_pkg::SEQ_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Registered one-cycle action strobes and the registered tuning busy level
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pad_refresh_o <= 1'b0;
         prox_refresh_o <= 1'b0;
         tune_start_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         pad_refresh_o <= (state_d == control_byte_low_pkg::SEQ_PAD_REFRESH);
         prox_refresh_o <= (state_d == control_byte_low_pkg::SEQ_PROX_REFRESH);
         tune_start_o <= (state_d == control_byte_low_pkg::SEQ_TUNE_START);
         busy_o <= (state_d == control_byte_low_pkg::SEQ_TUNE_START)
            || (state_d == control_byte_low_pkg::SEQ_TUNE_WAIT)
            || tune_pend_q || (take_i && tune_req_i);
      end
   end

endmodule // deferred_action_sequencer
`default_nettype wire

/* sim/control_byte_low_props.sv */
/* Checker for the low control byte block.
   Assumes it is bound to control_byte_low_actions and sees only its ports. */
`default_nettype none
module control_byte_low_props (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic data_valid_i,
   input wire logic window_open_i,
   input wire logic cycle_tick_i,
   input wire logic activity_i,
   input wire logic force_window_i,
   input wire logic auto_choice_prox_i,
   input wire logic [7:0] control_byte_low_o,
   input wire logic proximity_charge_mode_o,
   input wire logic window_start_o,
   input wire logic pad_refresh_o,
   input wire logic prox_refresh_o,
   input wire logic tune_start_o,
   input wire logic tune_busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_take;
      $fell(window_open_i) && !data_valid_i && !$past(data_valid_i);
   endsequence
   sequence s_calm;
      $stable(control_byte_low_o) && $stable(auto_choice_prox_i);
   endsequence
   property p_pad; s_take ##0 control_byte_low_o[1] |-> ##[2:3] pad_refresh_o; endproperty
   a_pad: assert property (p_pad) else $error("pad refresh late");
   property p_order;
      s_take ##0 (control_byte_low_o[1] && control_byte_low_o[4])
         |-> ##[2:3] pad_refresh_o ##1 prox_refresh_o;
   endproperty
   a_order: assert property (p_order) else $error("refresh order");
   property p_tune; s_take ##0 control_byte_low_o[2] |-> ##[2:5] tune_start_o && tune_busy_o;
   endproperty
   a_tune: assert property (p_tune) else $error("tune start late");
   property p_clear;
      s_take ##0 (|(control_byte_low_o & control_byte_low_pkg::ONE_SHOT_MASK))
         |-> ##[2:3] !(|(control_byte_low_o & control_byte_low_pkg::ONE_SHOT_MASK));
   endproperty
   a_clear: assert property (p_clear) else $error("one-shot not cleared");
   property p_gate; tune_busy_o |-> !window_start_o; endproperty
   a_gate: assert property (p_gate) else $error("window while tuning");
   property p_mode;
      s_calm ##1 s_calm |-> proximity_charge_mode_o ==
         (control_byte_low_o[6] ? auto_choice_prox_i : control_byte_low_o[3]);
   endproperty
   a_mode: assert property (p_mode) else $error("charge mode wrong");
   property p_win;
      cycle_tick_i && !control_byte_low_o[0] && !window_open_i && !$past(window_open_i)
         && !tune_busy_o && !$past(tune_busy_o) && $stable(control_byte_low_o)
         |=> window_start_o;
   endproperty
   a_win: assert property (p_win) else $error("window missing");
   property p_skip;
      cycle_tick_i && control_byte_low_o[0] && $stable(control_byte_low_o) && !activity_i
         && !force_window_i && !tune_busy_o && !$past(tune_busy_o) |=> !window_start_o;
   endproperty
   a_skip: assert property (p_skip) else $error("window not skipped");
endmodule // control_byte_low_props
bind control_byte_low_actions control_byte_low_props u_props (.clock_i, .arst_n_i,
   .data_valid_i, .window_open_i, .cycle_tick_i, .activity_i, .force_window_i,
   .auto_choice_prox_i, .control_byte_low_o, .proximity_charge_mode_o, .window_start_o,
   .pad_refresh_o, .prox_refresh_o, .tune_start_o, .tune_busy_o);
`default_nettype wire

/* sim/host_model.sv */
/* Host model: one write transaction inside one communication window.
   Assumes the bench supplies the clock and calls xfer. */
`default_nettype none
module host_model (
   input wire logic clock_i,
   output logic addr_valid_o,
   output logic [7:0] addr_o,
   output logic data_valid_o,
   output logic [7:0] data_o,
   output logic window_open_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {addr_valid_o, data_valid_o, window_open_o, addr_o, data_o} = 19'h0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   task automatic xfer(input logic [7:0] a, input logic [7:0] lo);
      step(1);
      window_open_o = 1'b1;
      addr_valid_o = 1'b1;
      addr_o = a;
      step(1);
      addr_valid_o = 1'b0;
      addr_o = ~a;
      data_valid_o = 1'b1;
      data_o = lo;
      step(1);
      data_o = ~lo;
      step(1);
      data_valid_o = 1'b0;
      data_o = ~data_o;
      step(3);
      window_open_o = 1'b0;
   endtask
endmodule // host_model
`default_nettype wire

/* sim/tb_control_byte_low_actions.sv */
/* Self-checking bench for control_byte_low_actions.
   Assumes the package, the design, the host model and the checker are compiled. */
`default_nettype none
module tb_control_byte_low_actions;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, arst_n_i, addr_valid_i, data_valid_i, window_open_i, cycle_tick_i;
   logic activity_i, force_window_i, auto_choice_prox_i, tune_done_i, exp_mode;
   logic [7:0] addr_i, data_i, control_byte_low_o, lo;
   logic proximity_charge_mode_o, window_start_o, pad_refresh_o, prox_refresh_o;
   logic tune_start_o, tune_prox_mode_o, tune_busy_o;
   logic [3:0] strobes;
   logic [3:0] exp_q[$];
   logic [31:0] r;
   logic [31:0] seed = 32'h95df;
   int miscompares = 0;
   int total_checks = 0;
   assign strobes = {pad_refresh_o, prox_refresh_o, tune_start_o, window_start_o};
   control_byte_low_actions uut (.clock_i, .arst_n_i, .addr_valid_i, .addr_i, .data_valid_i,
      .data_i, .window_open_i, .cycle_tick_i, .activity_i, .force_window_i,
      .auto_choice_prox_i, .tune_done_i, .control_byte_low_o, .proximity_charge_mode_o,
      .window_start_o, .pad_refresh_o, .prox_refresh_o, .tune_start_o, .tune_prox_mode_o,
      .tune_busy_o);
   host_model u_host (.clock_i, .addr_valid_o(addr_valid_i), .addr_o(addr_i),
      .data_valid_o(data_valid_i), .data_o(data_i), .window_open_o(window_open_i));
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   function automatic logic [31:0] next_rand();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic [3:0] pop_exp();
      return (exp_q.size() > 0) ? exp_q.pop_front() : 4'h0;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Every strobe takes the oldest expectation
   always @(posedge clock_i) begin
      if (arst_n_i && (|strobes)) begin
         check({4'h0, strobes}, {4'h0, pop_exp()});
      end
   end
   initial begin
      {cycle_tick_i, activity_i, force_window_i, auto_choice_prox_i, tune_done_i} = 5'h0;
      arst_n_i = 1'b0;
      cyc(10);
      arst_n_i = 1'b1;
      check(control_byte_low_o, control_byte_low_pkg::CONTROL_LOW_RESET);
      for (int i = 0; i < 24; i++) begin
         r = next_rand();
         lo = r[7:0];
         activity_i = r[10] & r[11];
         force_window_i = r[9] & r[12];
         auto_choice_prox_i = r[8];
         exp_mode = lo[6] ? r[8] : lo[3];
         if (lo[1]) exp_q.push_back(4'b1000);
         if (lo[4]) exp_q.push_back(4'b0100);
         if (lo[2]) exp_q.push_back(4'b0010);
         if (!lo[0] || activity_i || force_window_i) exp_q.push_back(4'b0001);
         u_host.xfer(control_byte_low_pkg::CONTROL_CMD_ADDR, lo);
         cycle_tick_i = lo[2]; // Tick in the take cycle must wait
         cyc(1);
         cycle_tick_i = 1'b0;
         cyc(5);
         cycle_tick_i = 1'b1;
         cyc(1);
         cycle_tick_i = 1'b0;
         cyc(2);
         tune_done_i = lo[2];
         cyc(1);
         tune_done_i = 1'b0;
         cyc(5);
         check(control_byte_low_o, lo & ~control_byte_low_pkg::ONE_SHOT_MASK);
         check({7'h0, proximity_charge_mode_o}, {7'h0, exp_mode});
         if (lo[2]) check({7'h0, tune_prox_mode_o}, {7'h0, exp_mode});
      end
      u_host.xfer(8'h11, 8'h17);
      cyc(8);
      check(control_byte_low_o, lo & ~control_byte_low_pkg::ONE_SHOT_MASK);
      check(8'(exp_q.size()), 8'h00);
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clock_i);
      miscompares++;
      close_out();
   end
endmodule // tb_control_byte_low_actions
`default_nettype wire
